// ===== rtl/fse_pkg.sv
/*
 Package of the flash status and error flag block: register offsets,
 bit positions, reset values and the event carriers.
 Assumes a 32-bit APB with byte addresses and one word per register.
*/
package fse_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] FSE_OFF_STATUS = 8'h00;
  localparam logic [7:0] FSE_OFF_ERR_STATUS = 8'h04;
  localparam logic [7:0] FSE_OFF_CONFIG = 8'h08;
  localparam logic [7:0] FSE_OFF_ERR_CONFIG = 8'h0c;

  ////////////////////////////////////////////////////////////////////////
  // Status register fields
  localparam int FSE_B_CMD_COMPLETE_FLAG = 7;
  localparam int FSE_B_ACCESS_ERROR_FLAG = 5;
  localparam int FSE_B_PVIOL = 4;
  localparam int FSE_B_BUSY = 3;
  localparam int FSE_B_RSVD = 2;
  localparam int FSE_B_CSTAT_HI = 1;
  localparam int FSE_B_CSTAT_LO = 0;

  // Error status fields
  localparam int FSE_B_DFAULT = 1;
  localparam int FSE_B_SFAULT = 0;

  // Config fields
  localparam int FSE_B_CMD_COMPLETE_IRQ_EN = 7;
  localparam int FSE_B_IGNORE_SINGLE_FAULT = 4;
  localparam int FSE_B_FORCE_DOUBLE_FAULT = 1;
  localparam int FSE_B_FORCE_SINGLE_FAULT = 0;

  // Error config fields
  localparam int FSE_B_DOUBLE_FAULT_IRQ_EN = 1;
  localparam int FSE_B_SINGLE_FAULT_IRQ_EN = 0;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] FSE_RST_STATUS = 8'h80;
  localparam logic [7:0] FSE_RST_ERR_STATUS = 8'h00;
  localparam logic [7:0] FSE_RST_CONFIG = 8'h00;
  localparam logic [7:0] FSE_RST_ERR_CONFIG = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Events from the command sequencer
  typedef struct packed {
    logic cmd_done;        // Command finished
    logic access_error;    // Sequence violated or illegal command
    logic prot_violation;  // Program/erase hit a protected range
    logic [1:0] cstat_set; // Completion status bits to set
  } fse_cmd_evt_t;

  // Result of one array read
  typedef struct packed {
    logic valid;        // Array read done this cycle
    logic single_fault; // Single-bit fault found and corrected
    logic double_fault; // Double-bit fault found
    logic collision;    // Read hit a block busy with a command
  } fse_read_evt_t;

endpackage : fse_pkg

// ===== rtl/fse_flags.sv
/*
 Flash status and error flag register bank behind an APB slave.
 Assumes the command sequencer and array read path run on pclk and
 hand over single-cycle event pulses; no synchroniser is needed.
*/
// How it works
// (R1) Command complete reads 1 when done; write 1 launches; low until done or violation.
// (R2) Access error set on command sequence violation or illegal command.
// (R3) While access error set, writing command complete neither clears nor launches.
// (R4) Write 1 clears access error; write 0 leaves it.
// (R5) Protection violation set on program/erase into a protected region.
// (R6) Protection violation blocks command launch and new command sequences.
// (R7) Write 1 clears protection violation; write 0 leaves it.
// (R8) Busy bit reads 1 while a command executes, 0 when idle.
// (R9) Bit 2 and unassigned status bits read 0, writes ignored.
// (R10) Completion status bits set by controller on command or reset-sequence errors.
// (R11) Status reset value may differ after reset-sequence double fault.
// (R12) Double fault set on double-bit array fault or read collision.
// (R13) Write 1 clears double fault; write 0 leaves it.
// (R14) Single fault set on collision, or on corrected fault unless ignore is set.
// (R15) Write 1 clears single fault; write 0 leaves it.
// (R16) Genuine parity fault sets at most one of single or double fault.
// (R17) Read collision sets both fault flags together.
// (R18) Command complete irq requested while flag set and enable is 1.
// (R19) Fault irq requested while fault flag set and its enable is 1.
// (R20) Ignore single fault suppresses single fault flag and its irq for corrected faults only; collisions and forced faults still set it.
// (R21) Force double fault makes every array read set double fault.
// (R22) Writing 0 to command complete leaves it; each written 1 clears independently.
`timescale 1ns/1ps
`default_nettype none

module fse_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fse_pkg::fse_cmd_evt_t cmd_evt,
  input wire fse_pkg::fse_read_evt_t read_evt,
  input wire logic reset_seq_dfault,
  output logic cmd_launch,
  output logic cmd_seq_block,
  output logic cmd_complete_irq,
  output logic fault_irq
);
  import fse_pkg::*;

  logic cmd_complete_flag;
  logic access_error_flag;
  logic protection_violation_flag;
  logic controller_busy;
  logic [1:0] completion_status;
  logic double_fault_flag;
  logic single_fault_flag;
  logic cmd_complete_irq_en;
  logic ignore_single_fault;
  logic force_double_fault;
  logic force_single_fault;
  logic double_fault_irq_en;
  logic single_fault_irq_en;

  logic wr_access;
  logic rd_setup;
  logic mapped;
  logic wr_status;
  logic wr_err_status;
  logic wr_config;
  logic wr_err_config;
  logic launch_ok;
  logic cmd_end;
  logic set_sfault;
  logic set_dfault;
  logic [31:0] next_prdata;

  ////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states
  assign pready = 1'b1;
  assign mapped = (paddr == FSE_OFF_STATUS) || (paddr == FSE_OFF_ERR_STATUS) ||
                  (paddr == FSE_OFF_CONFIG) || (paddr == FSE_OFF_ERR_CONFIG);
  assign pslverr = psel && penable && !mapped;
  assign wr_access = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_status = wr_access && (paddr == FSE_OFF_STATUS);
  assign wr_err_status = wr_access && (paddr == FSE_OFF_ERR_STATUS);
  assign wr_config = wr_access && (paddr == FSE_OFF_CONFIG);
  assign wr_err_config = wr_access && (paddr == FSE_OFF_ERR_CONFIG);

  ////////////////////////////////////////////////////////////////////////
  // Command launch and completion
  // Launch checks the flags as they stand before this write, so one write
  // clearing an error and launching still refuses the launch.
  assign launch_ok = wr_status && pwdata[FSE_B_CMD_COMPLETE_FLAG] && cmd_complete_flag &&
                     !access_error_flag && !protection_violation_flag; // (R3) (R6)
  assign cmd_end = cmd_evt.cmd_done || cmd_evt.access_error || cmd_evt.prot_violation;
  assign cmd_launch = launch_ok; // (R1)
  assign cmd_seq_block = protection_violation_flag; // (R6)

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_complete_flag <= FSE_RST_STATUS[FSE_B_CMD_COMPLETE_FLAG];
    end else if (cmd_end) begin
      cmd_complete_flag <= 1'b1; // (R1)
    end else if (launch_ok) begin
      cmd_complete_flag <= 1'b0; // (R1) (R22)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      controller_busy <= FSE_RST_STATUS[FSE_B_BUSY];
    end else if (cmd_end) begin
      controller_busy <= 1'b0; // (R8)
    end else if (launch_ok) begin
      controller_busy <= 1'b1; // (R8)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_error_flag <= FSE_RST_STATUS[FSE_B_ACCESS_ERROR_FLAG];
    end else if (cmd_evt.access_error) begin
      access_error_flag <= 1'b1; // (R2)
    end else if (wr_status && pwdata[FSE_B_ACCESS_ERROR_FLAG]) begin
      access_error_flag <= 1'b0; // (R4) (R22)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protection_violation_flag <= FSE_RST_STATUS[FSE_B_PVIOL];
    end else if (cmd_evt.prot_violation) begin
      protection_violation_flag <= 1'b1; // (R5)
    end else if (wr_status && pwdata[FSE_B_PVIOL]) begin
      protection_violation_flag <= 1'b0; // (R7) (R22)
    end
  end

  // Cleared by the next launch; not writable by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      completion_status <= FSE_RST_STATUS[FSE_B_CSTAT_HI:FSE_B_CSTAT_LO];
    end else if (reset_seq_dfault || (cmd_evt.cstat_set != 2'h0)) begin
      completion_status <= completion_status | cmd_evt.cstat_set |
                           {reset_seq_dfault, reset_seq_dfault}; // (R10) (R11)
    end else if (launch_ok) begin
      completion_status <= 2'h0; // (R10)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array read faults
  // Collision or forced fault may set both; a genuine double fault masks
  // the single one so a real ECC result is never reported twice.
  assign set_dfault = read_evt.valid &&
                      (read_evt.double_fault || read_evt.collision || force_double_fault); // (R12) (R17) (R21)
  assign set_sfault = read_evt.valid &&
                      (read_evt.collision || force_single_fault ||
                       (read_evt.single_fault && !read_evt.double_fault && !ignore_single_fault)); // (R14) (R16) (R17) (R20)

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_fault_flag <= FSE_RST_ERR_STATUS[FSE_B_DFAULT];
    end else if (set_dfault) begin
      double_fault_flag <= 1'b1; // (R12)
    end else if (wr_err_status && pwdata[FSE_B_DFAULT]) begin
      double_fault_flag <= 1'b0; // (R13) (R22)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_fault_flag <= FSE_RST_ERR_STATUS[FSE_B_SFAULT];
    end else if (set_sfault) begin
      single_fault_flag <= 1'b1; // (R14)
    end else if (wr_err_status && pwdata[FSE_B_SFAULT]) begin
      single_fault_flag <= 1'b0; // (R15) (R22)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_complete_irq_en <= FSE_RST_CONFIG[FSE_B_CMD_COMPLETE_IRQ_EN];
      ignore_single_fault <= FSE_RST_CONFIG[FSE_B_IGNORE_SINGLE_FAULT];
      force_double_fault <= FSE_RST_CONFIG[FSE_B_FORCE_DOUBLE_FAULT];
      force_single_fault <= FSE_RST_CONFIG[FSE_B_FORCE_SINGLE_FAULT];
    end else if (wr_config) begin
      cmd_complete_irq_en <= pwdata[FSE_B_CMD_COMPLETE_IRQ_EN];
      ignore_single_fault <= pwdata[FSE_B_IGNORE_SINGLE_FAULT];
      force_double_fault <= pwdata[FSE_B_FORCE_DOUBLE_FAULT];
      force_single_fault <= pwdata[FSE_B_FORCE_SINGLE_FAULT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_fault_irq_en <= FSE_RST_ERR_CONFIG[FSE_B_DOUBLE_FAULT_IRQ_EN];
      single_fault_irq_en <= FSE_RST_ERR_CONFIG[FSE_B_SINGLE_FAULT_IRQ_EN];
    end else if (wr_err_config) begin
      double_fault_irq_en <= pwdata[FSE_B_DOUBLE_FAULT_IRQ_EN];
      single_fault_irq_en <= pwdata[FSE_B_SINGLE_FAULT_IRQ_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt requests, level
  assign cmd_complete_irq = cmd_complete_irq_en && cmd_complete_flag; // (R18)
  assign fault_irq = (double_fault_irq_en && double_fault_flag) ||
                     (single_fault_irq_en && single_fault_flag); // (R19) (R20)

  ////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase
  always_comb begin
    next_prdata = 32'h0000_0000; // (R9)
    case (paddr)
      FSE_OFF_STATUS: begin
        next_prdata[FSE_B_CMD_COMPLETE_FLAG] = cmd_complete_flag;
        next_prdata[FSE_B_ACCESS_ERROR_FLAG] = access_error_flag;
        next_prdata[FSE_B_PVIOL] = protection_violation_flag;
        next_prdata[FSE_B_BUSY] = controller_busy; // (R8)
        next_prdata[FSE_B_CSTAT_HI:FSE_B_CSTAT_LO] = completion_status;
      end
      FSE_OFF_ERR_STATUS: begin
        next_prdata[FSE_B_DFAULT] = double_fault_flag;
        next_prdata[FSE_B_SFAULT] = single_fault_flag;
      end
      FSE_OFF_CONFIG: begin
        next_prdata[FSE_B_CMD_COMPLETE_IRQ_EN] = cmd_complete_irq_en;
        next_prdata[FSE_B_IGNORE_SINGLE_FAULT] = ignore_single_fault;
        next_prdata[FSE_B_FORCE_DOUBLE_FAULT] = force_double_fault;
        next_prdata[FSE_B_FORCE_SINGLE_FAULT] = force_single_fault;
      end
      FSE_OFF_ERR_CONFIG: begin
        next_prdata[FSE_B_DOUBLE_FAULT_IRQ_EN] = double_fault_irq_en;
        next_prdata[FSE_B_SINGLE_FAULT_IRQ_EN] = single_fault_irq_en;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

endmodule : fse_flags

`default_nettype wire

// ===== test/fse_flags_asserts.sv
/*
 Checker of the flash status and error flag block, bound to its ports.
 Assumes the port names and types of fse_flags and one pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module fse_flags_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire fse_pkg::fse_cmd_evt_t cmd_evt,
  input wire fse_pkg::fse_read_evt_t read_evt,
  input wire logic reset_seq_dfault,
  input wire logic cmd_launch,
  input wire logic cmd_seq_block,
  input wire logic cmd_complete_irq,
  input wire logic fault_irq
);
  import fse_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // Status write in access phase; any command-ending event
  wire logic st_wr = psel && penable && pwrite && (paddr == 8'h00);
  wire logic cmd_end = cmd_evt.cmd_done || cmd_evt.access_error || cmd_evt.prot_violation;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////
  property p_pv_set; cmd_evt.prot_violation |=> cmd_seq_block; endproperty
  a_pv_set: assert property (p_pv_set) else $error("protection flag not set");
  property p_pv_hold; cmd_seq_block && !(st_wr && pwdata[4]) |=> cmd_seq_block; endproperty
  a_pv_hold: assert property (p_pv_hold) else $error("protection flag lost");
  property p_pv_clr; cmd_seq_block && st_wr && pwdata[4] && !cmd_evt.prot_violation |=> !cmd_seq_block;
  endproperty
  a_pv_clr: assert property (p_pv_clr) else $error("protection flag not cleared");
  property p_pv_block; cmd_seq_block |-> !cmd_launch; endproperty
  a_pv_block: assert property (p_pv_block) else $error("launch under protection fault");
  property p_launch_cause; cmd_launch |-> st_wr && pwdata[7]; endproperty
  a_launch_cause: assert property (p_launch_cause) else $error("launch without write");
  // Flag is low after a launch; a relaunch two cycles on needs an end event between
  property p_launch_once; cmd_launch && !cmd_end |=> !cmd_launch ##1 (!cmd_launch || $past(cmd_end));
  endproperty
  a_launch_once: assert property (p_launch_once) else $error("launch repeated");
  property p_irq_drop; cmd_launch && !cmd_end |=> !cmd_complete_irq; endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("complete irq after launch");
  property p_rsvd; psel && !penable && !pwrite && paddr == 8'h00 |=> prdata[31:8] == 24'h0 && !prdata[6]
    && !prdata[2]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bits nonzero");

  c_launch: cover property (cmd_launch);
  c_collide: cover property (read_evt.valid && read_evt.collision);
  c_pv_clr: cover property (cmd_seq_block && st_wr && pwdata[4]);
endmodule : fse_flags_asserts

`default_nettype wire

// ===== test/tb.sv
/*
 Self-checking bench of the flash status and error flag block.
 Assumes the APB slave answers with pready and events are pclk pulses.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb;
  import fse_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, cmd_launch, cmd_seq_block, cmd_complete_irq, fault_irq, rs_dfault = 1'b0, se;
  fse_cmd_evt_t cmd_evt = '0;
  fse_read_evt_t read_evt = '0;
  int errors = 0, cmp_count = 0, launches = 0;

  fse_flags i_fse_flags (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_evt(cmd_evt),
    .read_evt(read_evt), .reset_seq_dfault(rs_dfault), .cmd_launch(cmd_launch),
    .cmd_seq_block(cmd_seq_block), .cmd_complete_irq(cmd_complete_irq), .fault_irq(fault_irq));

  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) if (cmd_launch === 1'b1) launches++;
  initial begin repeat (20000) @(posedge pclk); errors++; conclude(); end

  ////////////////////////////////////////////////////////////////////////
  task conclude();
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // One APB transfer; no wait states assumed, bounded wait instead
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk); psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    for (n = 0; n < 20; n++) begin @(posedge pclk); if (pready === 1'b1) break; end
    rd = prdata; se = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n == 20) begin errors++; conclude(); end
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d); apb(1'b1, a, {24'h0, d}); endtask : wr
  task rc(input logic [7:0] a, input logic [7:0] e); apb(1'b0, a, 32'h0); `CHK("reg", {24'h0, e}, rd) endtask : rc
  task evt(input logic [4:0] c, input logic [3:0] r, input logic d);
    @(posedge pclk); cmd_evt <= c; read_evt <= r; rs_dfault <= d;
    @(posedge pclk); cmd_evt <= '0; read_evt <= '0; rs_dfault <= 1'b0;
  endtask : evt
  task settle(); @(posedge pclk); #1; endtask : settle

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rc(8'h00, 8'h80);
    rc(8'h04, 8'h00); rc(8'h08, 8'h00); rc(8'h0c, 8'h00);
    apb(1'b0, 8'h10, 32'h0); `CHK("unmapped", 33'h1_0000_0000, {se, rd})
    wr(8'h08, 8'h80); settle(); `CHK("cc_irq", 1'b1, cmd_complete_irq)
    // All-ones write launches and must not set reserved bits
    wr(8'h00, 8'hff); rc(8'h00, 8'h08);
    `CHK("cc_irq", 1'b0, cmd_complete_irq)
    wr(8'h00, 8'h80); wr(8'h00, 8'h00); rc(8'h00, 8'h08);
    evt(5'h11, 4'h0, 1'b0); rc(8'h00, 8'h81);
    evt(5'h08, 4'h0, 1'b0); rc(8'h00, 8'ha1);
    wr(8'h00, 8'h80); wr(8'h00, 8'h00); rc(8'h00, 8'ha1);
    wr(8'h00, 8'h20); rc(8'h00, 8'h81);
    evt(5'h04, 4'h0, 1'b0); rc(8'h00, 8'h91);
    `CHK("seq_block", 1'b1, cmd_seq_block)
    wr(8'h00, 8'h80); wr(8'h00, 8'h00); rc(8'h00, 8'h91);
    wr(8'h00, 8'h30); rc(8'h00, 8'h81);
    `CHK("launches", 1, launches)
    evt(5'h00, 4'h0, 1'b1); rc(8'h00, 8'h83);
    wr(8'h0c, 8'h03);
    evt(5'h00, 4'hc, 1'b0); rc(8'h04, 8'h01);
    `CHK("fault_irq", 1'b1, fault_irq)
    wr(8'h04, 8'h00); rc(8'h04, 8'h01);
    wr(8'h04, 8'h01); rc(8'h04, 8'h00);
    evt(5'h00, 4'he, 1'b0); rc(8'h04, 8'h02);
    wr(8'h04, 8'h00); rc(8'h04, 8'h02);
    wr(8'h04, 8'h02); rc(8'h04, 8'h00);
    evt(5'h00, 4'h9, 1'b0); rc(8'h04, 8'h03);
    wr(8'h04, 8'h03); rc(8'h04, 8'h00);
    `CHK("fault_irq", 1'b0, fault_irq)
    wr(8'h08, 8'h10); evt(5'h00, 4'hc, 1'b0); rc(8'h04, 8'h00);
    wr(8'h08, 8'h02); evt(5'h00, 4'h8, 1'b0); rc(8'h04, 8'h02);
    `CHK("fault_irq", 1'b1, fault_irq)
    conclude();
  end
endmodule : tb

bind fse_flags fse_flags_asserts i_fse_flags_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cmd_evt(cmd_evt), .read_evt(read_evt), .reset_seq_dfault(reset_seq_dfault),
  .cmd_launch(cmd_launch), .cmd_seq_block(cmd_seq_block), .cmd_complete_irq(cmd_complete_irq),
  .fault_irq(fault_irq));

`default_nettype wire
